/* src/rate_gen_pkg.sv */
// constants, field layouts and carrier types of the serial bit-rate generator
package rate_gen_pkg;

  // ****************************************************************
  // register bus
  // ****************************************************************
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] TX_CTRL_OFFSET   = 3'h0;
  localparam logic [ADDR_W-1:0] RX_CTRL_OFFSET   = 3'h1;
  localparam logic [ADDR_W-1:0] RATE_CTRL_OFFSET = 3'h2;
  localparam logic [ADDR_W-1:0] DIV_LOW_OFFSET   = 3'h3;
  localparam logic [ADDR_W-1:0] DIV_HIGH_OFFSET  = 3'h4;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned TX_MASTER_BIT     = 7;
  localparam int unsigned TX_SYNC_BIT       = 4;
  localparam int unsigned TX_HIGH_SPEED_BIT = 2;
  localparam int unsigned TX_SHIFT_EMPTY    = 1;
  localparam int unsigned RX_PORT_EN_BIT    = 7;
  localparam int unsigned RATE_IDLE_BIT     = 6;
  localparam int unsigned RATE_WIDE_BIT     = 3;

  // writable bits per register; the rest read as their fixed value
  localparam logic [DATA_W-1:0] TX_WR_MASK   = 8'hFD;
  localparam logic [DATA_W-1:0] RX_WR_MASK   = 8'hF8;
  localparam logic [DATA_W-1:0] RATE_WR_MASK = 8'h9B;
  // fixed read values: shift register empty, receive idle
  localparam logic [DATA_W-1:0] TX_RO_VALUE   = 8'h02;
  localparam logic [DATA_W-1:0] RATE_RO_VALUE = 8'h40;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] TX_CTRL_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] RX_CTRL_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] RATE_CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIV_BYTE_RESET  = 8'h00;

  // ****************************************************************
  // divide ratios: 4 from the prescaler, then a post divide of m
  // ****************************************************************
  localparam int unsigned PRE_W = 2;
  localparam int unsigned POST_W = 4;
  localparam logic [PRE_W-1:0]  PRE_LAST  = 2'h3;   // prescale by 4
  localparam logic [POST_W-1:0] POST_BY16 = 4'hF;   // 64 = 4 * 16
  localparam logic [POST_W-1:0] POST_BY4  = 4'h3;   // 16 = 4 * 4
  localparam logic [POST_W-1:0] POST_BY1  = 4'h0;   // 4  = 4 * 1

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic port_enable;
    logic sync_mode;
    logic master;
    logic high_speed_select;
    logic wide_divisor_select;
  } rate_cfg_type;

  typedef struct packed {
    logic bit_tick;
    logic quarter_tick;
    logic rx_level;
    logic rx_level_valid;
  } rate_status_type;

  typedef enum logic [2:0] {
    SAMPLE_IDLE   = 3'b001,
    SAMPLE_SECOND = 3'b010,
    SAMPLE_THIRD  = 3'b100
  } sample_state_type;

endpackage

/* src/rate_stage.sv */
// one wrapping up-counter stage of the divider chain
module rate_stage
  import rate_gen_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] last,
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);

  // wrap when the count reaches the programmed last value
  assign wrap = enable && (count >= last);

  // clear has priority so a restart always begins at zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clear || wrap) begin
      count <= '0;
    end else if (enable) begin
      count <= count + 1'b1;
    end
  end

endmodule

/* src/serial_baud_rate_generator.sv */
// bit-rate generator with register port and majority receive sampler
//
// Chosen here: the placing of the registers and strobed register access.
module serial_baud_rate_generator
  import rate_gen_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              receive_input,
  output rate_cfg_type           cfg,
  output rate_status_type        status
);

  // ****************************************************************
  // registers
  // ****************************************************************
  // register map, one byte each:
  //   offset 0 transmit control: master, sync, high speed; bit 1 reads 1
  //   offset 1 receive control: port enable in bit 7
  //   offset 2 rate control: wide divisor in bit 3; bit 6 reads 1
  //   offsets 3 and 4 hold the low and high divisor bytes
  //   offsets 5 to 7 read as zero and ignore writes
  logic [DATA_W-1:0] transmit_control_status;
  logic [DATA_W-1:0] receive_control_status;
  logic [DATA_W-1:0] rate_control;
  logic [DATA_W-1:0] divisor_high_byte;
  logic [DATA_W-1:0] divisor_low_byte;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // an unmapped offset hits nothing, so its strobes do nothing
  wire hit_tx   = (addr == TX_CTRL_OFFSET);
  wire hit_rx   = (addr == RX_CTRL_OFFSET);
  wire hit_rate = (addr == RATE_CTRL_OFFSET);
  wire hit_low  = (addr == DIV_LOW_OFFSET);
  wire hit_high = (addr == DIV_HIGH_OFFSET);

  wire wr_tx   = wr_en && hit_tx;
  wire wr_rx   = wr_en && hit_rx;
  wire wr_rate = wr_en && hit_rate;
  wire wr_low  = wr_en && hit_low;
  wire wr_high = wr_en && hit_high;

  // a write to either divisor byte restarts the chain
  wire divisor_write = wr_low || wr_high;

  // ****************************************************************
  // register writes
  // ****************************************************************
  // only writable bits are stored; fixed bits are merged on read
  // fixed bits are never stored, so no write can ever clear them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      transmit_control_status <= TX_CTRL_RESET;
      receive_control_status  <= RX_CTRL_RESET;
      rate_control            <= RATE_CTRL_RESET;
    end else begin
      if (wr_tx) begin
        transmit_control_status <= wr_data & TX_WR_MASK;
      end
      if (wr_rx) begin
        receive_control_status <= wr_data & RX_WR_MASK;
      end
      if (wr_rate) begin
        rate_control <= wr_data & RATE_WR_MASK;
      end
    end
  end

  // the divisor lives in two separate byte registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divisor_high_byte <= DIV_BYTE_RESET;
      divisor_low_byte  <= DIV_BYTE_RESET;
    end else begin
      if (wr_high) begin
        divisor_high_byte <= wr_data;
      end
      if (wr_low) begin
        divisor_low_byte <= wr_data;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [DATA_W-1:0] read_mux;

  // unmapped offsets read as zero
  always_comb begin
    read_mux = '0;
    if (hit_tx) begin
      read_mux = transmit_control_status | TX_RO_VALUE;
    end else if (hit_rx) begin
      read_mux = receive_control_status;
    end else if (hit_rate) begin
      read_mux = rate_control | RATE_RO_VALUE;
    end else if (hit_low) begin
      read_mux = divisor_low_byte;
    end else if (hit_high) begin
      read_mux = divisor_high_byte;
    end
  end

  // read data stand only in the cycle after the strobe
  // returning to zero afterwards means a stale byte never looks like
  // a fresh answer to a master that samples late
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= read_mux;
    end else begin
      rd_data <= '0;
    end
  end

  // ****************************************************************
  // configuration decode
  // ****************************************************************
  // master only matters to the transmit side; it is carried out on cfg
  // and has no effect on the divider
  wire port_enable = receive_control_status[RX_PORT_EN_BIT];
  wire sync_mode   = transmit_control_status[TX_SYNC_BIT];
  wire master      = transmit_control_status[TX_MASTER_BIT];
  wire high_speed  = transmit_control_status[TX_HIGH_SPEED_BIT];
  wire wide        = rate_control[RATE_WIDE_BIT];

  assign cfg.port_enable         = port_enable;
  assign cfg.sync_mode           = sync_mode;
  assign cfg.master              = master;
  assign cfg.high_speed_select   = high_speed;
  assign cfg.wide_divisor_select = wide;

  // narrow mode ignores the high byte's value; a write to it still restarts the chain
  wire [15:0] divisor_n = wide ? {divisor_high_byte, divisor_low_byte}
                               : {8'h00, divisor_low_byte};

  // post divide m after the fixed prescale of 4
  // overall ratio per bit, prescale included:
  //   async narrow low 64, async wide low 16
  //   async narrow high 16, async wide high 4
  //   synchronous 4 in either width, speed select unused
  logic [POST_W-1:0] post_last;
  always_comb begin
    post_last = POST_BY1;
    if (sync_mode) begin
      post_last = POST_BY1;
    end else if (!wide && !high_speed) begin
      post_last = POST_BY16;
    end else if (wide && !high_speed) begin
      post_last = POST_BY4;
    end else if (!wide && high_speed) begin
      post_last = POST_BY4;
    end else begin
      post_last = POST_BY1;
    end
  end

  // ****************************************************************
  // divider chain
  // ****************************************************************
  // chain timing after a clear:
  //   prescale wraps every 4 device clocks
  //   main stage wraps after n+1 prescale wraps: the quarter tick
  //   post stage wraps after m quarter ticks: the bit tick
  //   first quarter tick lands 4(n+1) clocks after the clearing edge
  // clearing all three stages, not just the main one, keeps the first
  // period exact at the cost of a phase jump on every rewrite
  // a disabled port holds the whole chain in reset
  wire chain_clear = divisor_write || !port_enable;

  logic [PRE_W-1:0]  pre_count;
  logic [15:0]       main_count;
  logic [POST_W-1:0] post_count;
  logic              pre_wrap;
  logic              main_wrap;
  logic              post_wrap;

  // every stage counts device clocks only; a slower power-managed
  // clock changes the rate and software must reprogram the divisor
  rate_stage #(.WIDTH(PRE_W)) prescale (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clear   (chain_clear),
    .enable  (port_enable),
    .last    (PRE_LAST),
    .count   (pre_count),
    .wrap    (pre_wrap)
  );

  // period of n+1 prescaled ticks
  rate_stage #(.WIDTH(16)) main_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clear   (chain_clear),
    .enable  (pre_wrap),
    .last    (divisor_n),
    .count   (main_count),
    .wrap    (main_wrap)
  );

  // mode dependent post divide gives the bit period
  rate_stage #(.WIDTH(POST_W)) postscale (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clear   (chain_clear),
    .enable  (main_wrap),
    .last    (post_last),
    .count   (post_count),
    .wrap    (post_wrap)
  );

  // a mode change mid-period can leave post_count above the new last;
  // the stage compares with >= so it still wraps on the next tick
  assign status.quarter_tick = main_wrap;
  assign status.bit_tick     = post_wrap;

  // ****************************************************************
  // majority sampler
  // ****************************************************************
  // centre of the bit: halfway through the post divide
  wire [POST_W-1:0] mid_index = post_last >> 1;
  wire sample_start = main_wrap && (post_count == mid_index);

  sample_state_type  sample_state;
  sample_state_type  next_sample_state;
  logic [1:0]        samples;
  logic              rx_level;
  logic              rx_level_valid;

  // the vote needs three clocks; the shortest chain period is four,
  // so a vote always ends before the next start can arrive
  // a start that falls while the vote is busy is ignored
  // three consecutive device clocks are sampled around the bit centre
  always_comb begin
    next_sample_state = sample_state;
    unique case (sample_state)
      SAMPLE_IDLE: begin
        if (sample_start) begin
          next_sample_state = SAMPLE_SECOND;
        end
      end
      SAMPLE_SECOND: begin
        next_sample_state = SAMPLE_THIRD;
      end
      SAMPLE_THIRD: begin
        next_sample_state = SAMPLE_IDLE;
      end
      default: begin
        next_sample_state = SAMPLE_IDLE;
      end
    endcase
    if (!port_enable) begin
      next_sample_state = SAMPLE_IDLE;
    end
  end

  // majority of two stored samples and the one taken now
  wire vote = (samples[0] & samples[1])
            | (samples[0] & receive_input)
            | (samples[1] & receive_input);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sample_state <= SAMPLE_IDLE;
    end else begin
      sample_state <= next_sample_state;
    end
  end

  // first two samples are stored, the third is voted directly
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      samples <= 2'h0;
    end else if (sample_state == SAMPLE_IDLE && sample_start) begin
      samples[0] <= receive_input;
    end else if (sample_state == SAMPLE_SECOND) begin
      samples[1] <= receive_input;
    end
  end

  // receive line idles high, so the decided level starts high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_level       <= 1'b1;
      rx_level_valid <= 1'b0;
    end else if (port_enable && sample_state == SAMPLE_THIRD) begin
      rx_level       <= vote;
      rx_level_valid <= 1'b1;
    end else begin
      rx_level_valid <= 1'b0;
    end
  end

  // rx_level holds the last decided level between votes
  assign status.rx_level       = rx_level;
  assign status.rx_level_valid = rx_level_valid;

endmodule

/* sim/rate_gen_checker.sv */
// checker of divider timing, vote sampler and register port
module rate_gen_checker
  import rate_gen_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              receive_input,
  input wire rate_cfg_type      cfg,
  input wire rate_status_type   status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ******
  // shadow state
  // ******
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic [18:0] cnt;
  logic [4:0]  qc;
  logic        armed;
  // expected quarter period and post ratio from the shadow copy
  wire [18:0] div_n = cfg.wide_divisor_select ? {3'h0, hi, lo} : {11'h000, lo};
  wire [18:0] per   = (div_n + 19'h1) << 2;
  wire [4:0]  m     = (cfg.sync_mode || (cfg.wide_divisor_select && cfg.high_speed_select))
                    ? 5'h01 : (cfg.wide_divisor_select || cfg.high_speed_select) ? 5'h04 : 5'h10;
  // only writes known to restart the chain keep the timing checks armed
  wire restart = addr == DIV_LOW_OFFSET || addr == DIV_HIGH_OFFSET
               || (addr == RX_CTRL_OFFSET && !cfg.port_enable && wr_data[RX_PORT_EN_BIT]);
  // cycles since the last register write or quarter tick, quarters since the last bit or write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lo    <= 8'h00;
      hi    <= 8'h00;
      cnt   <= 19'h00000;
      qc    <= 5'h00;
      armed <= 1'b0;
    end else if (wr_en) begin
      lo    <= (addr == DIV_LOW_OFFSET) ? wr_data : lo;
      hi    <= (addr == DIV_HIGH_OFFSET) ? wr_data : hi;
      cnt   <= 19'h00001;
      qc    <= 5'h00;
      armed <= restart;
    end else if (status.quarter_tick) begin
      cnt <= 19'h00001;
      qc  <= status.bit_tick ? 5'h00 : qc + 5'h01;
    end else begin
      cnt <= cnt + 19'h00001;
    end
  end
  sequence s_vote_start;
    status.quarter_tick && armed && qc == ((m - 5'h01) >> 1);
  endsequence
  sequence s_vote_done;
    ##3 status.rx_level_valid;
  endsequence
  // ******
  // assertions
  // ******
  a_read_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside the answer cycle");
  a_unmapped_zero: assert property (rd_en && addr > DIV_HIGH_OFFSET |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_quarter_period: assert property (status.quarter_tick && armed |-> cnt == per)
    else $error("quarter tick off period");
  a_quarter_due: assert property (cfg.port_enable && armed |-> cnt <= per)
    else $error("quarter tick missing");
  a_bit_ratio: assert property (status.quarter_tick && armed |->
    status.bit_tick == (qc == m - 5'h01))
    else $error("bit tick ratio wrong");
  a_ticks_off: assert property (!cfg.port_enable |-> !status.quarter_tick)
    else $error("tick while port disabled");
  a_bit_on_quarter: assert property (status.bit_tick |-> status.quarter_tick)
    else $error("bit tick without quarter tick");
  a_vote_start: assert property (disable iff (!rst_n || wr_en)
    s_vote_start |-> s_vote_done)
    else $error("vote result late");
  a_vote_value: assert property (status.rx_level_valid |-> status.rx_level ==
    (($past(receive_input, 1) + $past(receive_input, 2) + $past(receive_input, 3)) >= 2))
    else $error("vote result wrong");
  a_valid_pulse: assert property (status.rx_level_valid |=> !status.rx_level_valid)
    else $error("valid longer than one cycle");
endmodule

bind serial_baud_rate_generator rate_gen_checker u_rate_gen_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .receive_input(receive_input), .cfg(cfg),
  .status(status)
);

/* sim/remote_peer.sv */
// remote serial peer driving the receive line
module remote_peer (
  input  wire logic clk_sys,
  input  wire logic level,
  input  wire logic glitch_on,
  output logic      receive_input = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // line driver
  // ******
  logic [2:0] phase = 3'h0;
  // one bad cycle in five, so a vote never sees two wrong samples
  always @(posedge clk_sys) begin
    phase <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
    receive_input <= level ^ (glitch_on && phase == 3'h0);
  end
endmodule

/* sim/serial_baud_rate_generator_bench.sv */
// bench: register port, divide ratios, restart and vote sampling
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module serial_baud_rate_generator_bench
  import rate_gen_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // signals and parts
  // ******
  logic              clk_sys   = 1'b0;
  logic              rst_n     = 1'b0;
  logic [ADDR_W-1:0] addr      = 3'h0;
  logic [DATA_W-1:0] wr_data   = 8'h00;
  logic              wr_en     = 1'b0;
  logic              rd_en     = 1'b0;
  logic              level     = 1'b1;
  logic              glitch_on = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic              receive_input;
  rate_cfg_type      cfg;
  rate_status_type   status;
  int                err_total       = 0;
  int                samples_checked = 0;
  int                cycles          = 0;
  integer            seed            = 9;
  always #10 clk_sys = ~clk_sys;
  serial_baud_rate_generator u_serial_baud_rate_generator (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .receive_input(receive_input), .cfg(cfg),
    .status(status));
  remote_peer u_remote_peer (.clk_sys(clk_sys), .level(level), .glitch_on(glitch_on),
    .receive_input(receive_input));
  // ******
  // tasks and expectations
  // ******
  task automatic give_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    d = rd_data;
  endtask
  // cycles until bit tick (sel 0) or vote result (sel 1), bounded
  task automatic wait_for(input bit sel, output int k);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while ((sel ? status.rx_level_valid : status.bit_tick) !== 1'b1 && k < 70000);
  endtask
  function automatic logic [7:0] reg_exp(input logic [2:0] a, input logic [7:0] d);
    case (a)
      TX_CTRL_OFFSET:   return (d & TX_WR_MASK) | TX_RO_VALUE;
      RX_CTRL_OFFSET:   return d & RX_WR_MASK;
      RATE_CTRL_OFFSET: return (d & RATE_WR_MASK) | RATE_RO_VALUE;
      DIV_LOW_OFFSET:   return d;
      DIV_HIGH_OFFSET:  return d;
      default:          return 8'h00;
    endcase
  endfunction
  // narrow width drops the high byte; ratio m follows the mode bits
  function automatic int ticks_exp(input logic s, w, h, input logic [15:0] n);
    int m;
    m = (s || (w && h)) ? 1 : (w || h) ? 4 : 16;
    return 4 * ((w ? int'(n) : int'(n[7:0])) + 1) * m;
  endfunction
  // a hang counts as a failure; the run needs at most about 32000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 100000) begin
      err_total++;
      give_verdict();
    end
  end
  // ******
  // main sequence
  // ******
  initial begin
    logic [7:0] d;
    logic [7:0] lo;
    logic [7:0] hi;
    logic       s;
    logic       w;
    logic       h;
    int         k;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values, masks and unmapped places
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), d);
      `CHECK(d, reg_exp(3'(a), 8'h00))
      lo = 8'($random(seed));
      wr(3'(a), lo);
      rd(3'(a), d);
      `CHECK(d, reg_exp(3'(a), lo))
    end
    // every mode code, then a divisor rewrite in mid-count
    for (int i = 0; i < 8; i++) begin
      {s, w, h} = 3'(i);
      lo = 8'($random(seed)) & 8'h07;
      hi = w ? 8'($random(seed)) & 8'h01 : 8'($random(seed));
      wr(RX_CTRL_OFFSET, 8'h00);
      wr(TX_CTRL_OFFSET, {1'b1, 2'b00, s, 1'b0, h, 2'b00});
      wr(RATE_CTRL_OFFSET, {4'h0, w, 3'h0});
      wr(DIV_HIGH_OFFSET, hi);
      wr(DIV_LOW_OFFSET, lo);
      wr(RX_CTRL_OFFSET, 8'h80);
      wait_for(1'b0, k);
      `CHECK(k, ticks_exp(s, w, h, {hi, lo}))
      `CHECK(cfg, {1'b1, s, 1'b1, h, w})
      repeat (8'($random(seed)) & 8'h1F) @(posedge clk_sys);
      lo = 8'($random(seed)) & 8'h07;
      wr(DIV_LOW_OFFSET, lo);
      wait_for(1'b0, k);
      `CHECK(k, ticks_exp(s, w, h, {hi, lo}))
    end
    // majority vote against single-cycle glitches
    wr(RX_CTRL_OFFSET, 8'h00);
    wr(TX_CTRL_OFFSET, 8'h00);
    wr(RATE_CTRL_OFFSET, 8'h00);
    wr(DIV_LOW_OFFSET, 8'h00);
    wr(RX_CTRL_OFFSET, 8'h80);
    glitch_on <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      level <= (i == 0) ? 1'b0 : 1'($random(seed));
      wait_for(1'b1, k);
      wait_for(1'b1, k);
      `CHECK(status.rx_level, level)
    end
    // second reset in mid-run clears the registers
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(DIV_LOW_OFFSET, d);
    `CHECK(d, DIV_BYTE_RESET)
    `CHECK(cfg, 5'h00)
    give_verdict();
  end
endmodule
